// ===== common/ahr_defines.svh
`ifndef AHR_DEFINES_SVH
`define AHR_DEFINES_SVH

// domain codes of every sync domain field
`define AHR_DOM_LOW    3'h0
`define AHR_DOM_ONE    3'h1
`define AHR_DOM_TWO    3'h2

// clock pair codes of the input pair selectors
`define AHR_PAIR_LOW   3'h0
`define AHR_PAIR_ONE   3'h1
`define AHR_PAIR_TWO   3'h2

// source addresses on the stereo bus
`define AHR_SA_IN1     6'h01
`define AHR_SA_IN2     6'h09
`define AHR_SA_IN3     6'h0A
`define AHR_SA_VOL     6'h10
`define AHR_SA_ADC     6'h15
`define AHR_SA_MIX     6'h18

// slot and word length codes and their lengths in bits
`define AHR_LCODE_24   2'h0
`define AHR_LCODE_20   2'h1
`define AHR_LCODE_16   2'h2
`define AHR_LCODE_32   2'h3
`define AHR_LEN_24     6'h18
`define AHR_LEN_20     6'h14
`define AHR_LEN_16     6'h10
`define AHR_LEN_32     6'h20

// bit index of the word msb on the bus
`define AHR_WORD_MSB   5'h1F
`define AHR_POS_MAX    6'h3F

// master clock generation and buffering defaults
`define AHR_BCK_HALF   8
`define AHR_FRAME_BITS 64
`define AHR_FIFO_DEPTH 32

`endif

// ===== common/ahr_pkg.sv
package ahr_pkg;

   // frame clock formats of a clock pair
   typedef enum logic [2:0] {
      AHR_FMT_I2S  = 3'b000,
      AHR_FMT_DSP  = 3'b101,
      AHR_FMT_PCMS = 3'b110,
      AHR_FMT_PCML = 3'b111
   } ahr_fmt_e;

   typedef logic [5:0]  ahr_addr_t;
   typedef logic [63:0] ahr_pair_t;

endpackage

// ===== rtl/ahr_router.sv
`timescale 1ns/100ps
`default_nettype none
`include "ahr_defines.svh"

// plain fifo with a registered output stage; depth must be a power of two
module ahr_fifo #(
   parameter int WIDTH = 68,
   parameter int DEPTH = `AHR_FIFO_DEPTH
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // ready drops when full so the dispatcher holds its pending entries
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign push     = in_valid && in_ready;
   assign pop      = (cnt_q != '0) && (!out_valid || out_ready);

   // storage
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_q + AW'(push);
         rd_q  <= rd_q + AW'(pop);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // output stage keeps the memory mux off the ports
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data  <= mem_q[rd_q];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule // ahr_fifo

module ahr_router import ahr_pkg::*; #(
   parameter int BCK_HALF   = `AHR_BCK_HALF,
   parameter int FRAME_BITS = `AHR_FRAME_BITS,
   parameter int FIFO_DEPTH = `AHR_FIFO_DEPTH
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic [1:0]        bit_clock_pin_i,
   output logic      [1:0]        bit_clock_pin_o,
   output logic      [1:0]        bit_clock_pin_oe,
   input  wire logic [1:0]        frame_clock_pin_i,
   output logic      [1:0]        frame_clock_pin_o,
   output logic      [1:0]        frame_clock_pin_oe,
   input  wire logic [2:0]        serial_in_pin,
   output logic      [2:0]        serial_out_pin,
   input  wire logic [1:0]        master_slave_select,
   input  wire logic [1:0][2:0]   clock_format_field,
   input  wire logic [1:0]        edge_polarity_bit,
   input  wire logic [1:0][2:0]   master_domain_select,
   input  wire logic [2:0][2:0]   input_clock_pair_select,
   input  wire logic [2:0][1:0]   in_slot_length,
   input  wire logic [2:0][1:0]   in_word_length,
   input  wire logic [2:0]        in_bit_order,
   input  wire logic [2:0]        in_start_timing,
   input  wire logic [2:0][1:0]   out_slot_length,
   input  wire logic [2:0][1:0]   out_word_length,
   input  wire logic [2:0]        out_bit_order,
   input  wire logic [2:0]        out_start_timing,
   input  wire logic [2:0][2:0]   output_port_domain,
   input  wire logic [7:0][5:0]   out1_pair_source_select,
   input  wire logic [1:0][5:0]   out23_source_select,
   input  wire logic [2:0][5:0]   dac_source_select,
   input  wire logic [2:0][5:0]   volume_source_select,
   input  wire logic [3:0][5:0]   mixer_input_source_select,
   input  wire logic [2:0]        converter_group_domain,
   input  wire logic [2:0]        stereo_adc_domain,
   input  wire logic [2:0][2:0]   volume_domain,
   input  wire logic [1:0][2:0]   mixer_domain,
   input  wire logic [7:0][63:0]  int_src_data,
   output logic      [2:0][2:0]   in_port_domain,
   output logic                   dest_valid,
   input  wire logic              dest_ready,
   output logic      [3:0]        dest_index,
   output logic      [63:0]       dest_data
);
   localparam int FBW = $clog2(FRAME_BITS);

   logic [6:0]      pin_s1_q;
   logic [6:0]      pin_s2_q;
   wire  [2:0]      dom_launch;
   wire  [2:0]      dom_sample;
   wire  [2:0]      dom_fstart;
   wire  [2:0]      dom_fother;
   wire  [2:0]      dom_off;
   wire  [2:0]      dom_bck;
   wire  [2:0]      dom_frm;
   logic [2:0][2:0] ip_dom;
   logic [1:0]      p_dom  [6];
   logic [1:0]      p_slot [6];
   logic [1:0]      p_word [6];
   logic            p_ord  [6];
   logic            p_tim  [6];
   logic [31:0]     pub_q  [3][16];
   ahr_pair_t       bus_data [64];
   logic [2:0]      bus_dom  [64];

   function automatic logic [1:0] didx(input logic [2:0] c);
      return (c == `AHR_DOM_ONE || c == `AHR_DOM_TWO) ? c[1:0] : 2'h0;
   endfunction

   function automatic logic [5:0] len_of(input logic [1:0] c);
      case (c)
         `AHR_LCODE_20: return `AHR_LEN_20;
         `AHR_LCODE_16: return `AHR_LEN_16;
         `AHR_LCODE_32: return `AHR_LEN_32;
         default:       return `AHR_LEN_24;
      endcase
   endfunction

   function automatic logic frame_level(input ahr_fmt_e f, input logic [FBW-1:0] b);
      logic h;
      h = (b >= FBW'(FRAME_BITS / 2));
      case (f)
         AHR_FMT_DSP, AHR_FMT_PCML: return !h;
         AHR_FMT_PCMS:              return (b == '0);
         default:                   return h;
      endcase
   endfunction

   // pins come from another clock, two flops before anything looks
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {serial_in_pin, frame_clock_pin_i, bit_clock_pin_i};
         pin_s2_q <= pin_s1_q;
      end
   end

   // domain zero is the tied-low domain: no clocks, no events
   assign dom_launch[0] = 1'b0;
   assign dom_sample[0] = 1'b0;
   assign dom_fstart[0] = 1'b0;
   assign dom_fother[0] = 1'b0;
   assign dom_off[0]    = 1'b0;
   assign dom_bck[0]    = 1'b0;
   assign dom_frm[0]    = 1'b0;

   for (genvar d = 1; d < 3; d++) begin : g_dom
      localparam int X = d - 1;
      ahr_fmt_e        fmt;
      logic            pol;
      logic            is_i2s;
      logic            fedge;
      logic [15:0]     div_q;
      logic            gbck_q;
      logic            gfrm_q;
      logic [FBW-1:0]  bn_q;
      logic [FBW-1:0]  bn_nx;
      logic            dbck_q;
      logic            dbp_q;
      logic            dfrm_q;
      logic            dfl_q;
      assign fmt    = ahr_fmt_e'(clock_format_field[X]);
      assign pol    = edge_polarity_bit[X];
      assign is_i2s = !(fmt inside {AHR_FMT_DSP, AHR_FMT_PCMS, AHR_FMT_PCML});
      assign bn_nx  = (bn_q == FBW'(FRAME_BITS - 1)) ? '0 : bn_q + 1'b1;

      always_ff @(posedge clk_sys) begin
         if (!rst_b) begin
            div_q  <= '0;
            gbck_q <= 1'b0;
            gfrm_q <= 1'b0;
            bn_q   <= '0;
         end else if (div_q == 16'(BCK_HALF - 1)) begin
            div_q  <= '0;
            gbck_q <= ~gbck_q;
            if (gbck_q != pol) begin
               bn_q   <= bn_nx;
               gfrm_q <= frame_level(fmt, bn_nx);
            end
         end else begin
            div_q <= div_q + 16'h0001;
         end
      end

      always_ff @(posedge clk_sys) begin
         if (!rst_b) begin
            dbck_q <= 1'b0;
            dbp_q  <= 1'b0;
            dfrm_q <= 1'b0;
            dfl_q  <= 1'b0;
         end else begin
            dbck_q <= master_slave_select[X] ? gbck_q : pin_s2_q[X];
            dfrm_q <= master_slave_select[X] ? gfrm_q : pin_s2_q[2 + X];
            dbp_q  <= dbck_q;
            if (dom_launch[d]) begin
               dfl_q <= dfrm_q;
            end
         end
      end

      assign dom_launch[d] = (dbck_q == pol) && (dbp_q != pol);
      assign dom_sample[d] = (dbck_q != pol) && (dbp_q == pol);
      assign fedge         = dom_launch[d] && (dfrm_q != dfl_q);
      assign dom_fstart[d] = fedge && (is_i2s ? !dfrm_q : dfrm_q);
      assign dom_fother[d] = fedge && !dom_fstart[d];
      assign dom_off[d]    = is_i2s || (fmt == AHR_FMT_PCMS);
      assign dom_bck[d]    = dbck_q;
      assign dom_frm[d]    = dfrm_q;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         bit_clock_pin_o    <= '0;
         bit_clock_pin_oe   <= '0;
         frame_clock_pin_o  <= '0;
         frame_clock_pin_oe <= '0;
      end else begin
         for (int x = 0; x < 2; x++) begin
            bit_clock_pin_oe[x]   <= master_slave_select[x];
            frame_clock_pin_oe[x] <= master_slave_select[x];
            bit_clock_pin_o[x]    <= master_slave_select[x] &
                                     dom_bck[didx(master_domain_select[x])];
            frame_clock_pin_o[x]  <= master_slave_select[x] &
                                     dom_frm[didx(master_domain_select[x])];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         ip_dom[i] = `AHR_DOM_LOW;
         case (input_clock_pair_select[i])
            `AHR_PAIR_ONE: ip_dom[i] = master_slave_select[0] ?
                                       {1'b0, didx(master_domain_select[0])} : `AHR_DOM_ONE;
            `AHR_PAIR_TWO: ip_dom[i] = master_slave_select[1] ?
                                       {1'b0, didx(master_domain_select[1])} : `AHR_DOM_TWO;
            default:       ip_dom[i] = `AHR_DOM_LOW;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         in_port_domain <= '0;
      end else begin
         in_port_domain <= ip_dom;
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         p_dom[i]      = didx(ip_dom[i]);
         p_slot[i]     = in_slot_length[i];
         p_word[i]     = in_word_length[i];
         p_ord[i]      = in_bit_order[i];
         p_tim[i]      = in_start_timing[i];
         p_dom[i + 3]  = didx(output_port_domain[i]);
         p_slot[i + 3] = out_slot_length[i];
         p_word[i + 3] = out_word_length[i];
         p_ord[i + 3]  = out_bit_order[i];
         p_tim[i + 3]  = out_start_timing[i];
      end
   end

   always_comb begin
      for (int a = 0; a < 64; a++) begin
         bus_data[a] = '0;
         bus_dom[a]  = `AHR_DOM_LOW;
      end
      for (int p = 0; p < 8; p++) begin
         bus_data[int'(`AHR_SA_IN1) + p] = {pub_q[0][2 * p], pub_q[0][2 * p + 1]};
         bus_dom[int'(`AHR_SA_IN1) + p]  = ip_dom[0];
      end
      bus_data[`AHR_SA_IN2] = {pub_q[1][0], pub_q[1][1]};
      bus_dom[`AHR_SA_IN2]  = ip_dom[1];
      bus_data[`AHR_SA_IN3] = {pub_q[2][0], pub_q[2][1]};
      bus_dom[`AHR_SA_IN3]  = ip_dom[2];
      for (int v = 0; v < 3; v++) begin
         bus_data[int'(`AHR_SA_VOL) + v] = int_src_data[v];
         bus_dom[int'(`AHR_SA_VOL) + v]  = volume_domain[v];
         bus_data[int'(`AHR_SA_ADC) + v] = int_src_data[3 + v];
         bus_dom[int'(`AHR_SA_ADC) + v]  = (v == 0) ? stereo_adc_domain : converter_group_domain;
      end
      for (int m = 0; m < 2; m++) begin
         bus_data[int'(`AHR_SA_MIX) + m] = int_src_data[6 + m];
         bus_dom[int'(`AHR_SA_MIX) + m]  = mixer_domain[m];
      end
   end

   // serial engines: ports 0-2 receive, 3-5 transmit; the first of each is tdm capable
   for (genvar i = 0; i < 6; i++) begin : g_port
      localparam logic [3:0] CHMAX = (i == 0 || i == 3) ? 4'hF : 4'h1;
      logic       evl;
      logic       evs;
      logic       fst;
      logic       fot;
      logic [5:0] off;
      logic [5:0] pos_q;
      logic [5:0] pos_d;
      logic [3:0] ch_q;
      logic [3:0] ch_d;
      logic       act_q;
      logic       act_d;
      logic       newc;
      logic [5:0] slot_q;
      logic [5:0] word_q;
      logic       ord_q;
      logic       tim_q;
      logic [5:0] k;
      logic [5:0] r;
      logic       bit_ok;
      logic [4:0] bidx;
      assign evl = dom_launch[p_dom[i]];
      assign evs = dom_sample[p_dom[i]];
      assign fst = dom_fstart[p_dom[i]];
      assign fot = dom_fother[p_dom[i]];
      assign off = {5'h00, dom_off[p_dom[i]]};
      assign k   = pos_q - off;
      assign r      = ord_q ? slot_q - 6'h01 - k : k;
      assign bit_ok = act_q && (pos_q >= off) && (k < slot_q) && (r < word_q);
      assign bidx   = `AHR_WORD_MSB - r[4:0];

      always_comb begin
         pos_d = pos_q;
         ch_d  = ch_q;
         act_d = act_q;
         newc  = 1'b0;
         if (fst) begin
            pos_d = '0;
            ch_d  = '0;
            act_d = 1'b1;
            newc  = 1'b1;
         end else if (fot && !tim_q && act_q && ch_q == '0) begin
            pos_d = '0;
            ch_d  = 4'h1;
            newc  = 1'b1;
         end else if (act_q) begin
            if (tim_q && pos_q == off + slot_q - 6'h01) begin
               if (ch_q < CHMAX) begin
                  pos_d = off;
                  ch_d  = ch_q + 4'h1;
                  newc  = 1'b1;
               end else begin
                  act_d = 1'b0;
               end
            end else if (pos_q != `AHR_POS_MAX) begin
               pos_d = pos_q + 6'h01;
            end
         end
      end

      // channel position advances on launch edges only
      always_ff @(posedge clk_sys) begin
         if (!rst_b) begin
            pos_q <= '0;
            ch_q  <= '0;
            act_q <= 1'b0;
         end else if (evl) begin
            pos_q <= pos_d;
            ch_q  <= ch_d;
            act_q <= act_d;
         end
      end

      always_ff @(posedge clk_sys) begin
         if (!rst_b) begin
            slot_q <= `AHR_LEN_24;
            word_q <= `AHR_LEN_24;
            ord_q  <= 1'b0;
            tim_q  <= 1'b0;
         end else if (evl && fst) begin
            slot_q <= len_of(p_slot[i]);
            word_q <= len_of(p_word[i]);
            ord_q  <= p_ord[i];
            tim_q  <= p_tim[i];
         end
      end

      if (i < 3) begin : g_in
         logic [31:0] cap_q [16];
         always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
               for (int c = 0; c < 16; c++) begin
                  cap_q[c]    <= '0;
                  pub_q[i][c] <= '0;
               end
            end else begin
               if (evl && fst) begin
                  pub_q[i] <= cap_q;
               end
               if (evl && newc) begin
                  cap_q[ch_d] <= '0;
               end else if (evs && bit_ok) begin
                  cap_q[ch_q][bidx] <= pin_s2_q[4 + i];
               end
            end
         end
      end else begin : g_out
         localparam int J   = i - 3;
         localparam int J23 = (i > 3) ? i - 4 : 0;
         logic [31:0] ow_q [16];
         logic        so_q;
         always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
               for (int c = 0; c < 16; c++) begin
                  ow_q[c] <= '0;
               end
            end else if (evl && fst) begin
               for (int p = 0; p < 8; p++) begin
                  if (J == 0 || p == 0) begin
                     {ow_q[2 * p], ow_q[2 * p + 1]} <= bus_data[(J == 0) ?
                        out1_pair_source_select[p] : out23_source_select[J23]];
                  end
               end
            end
         end

         // bit leaves one clock after the launch edge moved the position
         always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
               so_q <= 1'b0;
            end else begin
               so_q <= bit_ok & ow_q[ch_q][bidx];
            end
         end
         assign serial_out_pin[J] = so_q;
      end
   end

   // internal destinations: 0-2 dac, 3-5 volume, 6-9 mixer inputs
   logic [5:0]  dsel [10];
   logic [9:0]  dfs;
   logic [63:0] dq_q [10];
   logic [9:0]  pend_q;
   logic [3:0]  pick;
   logic        f_ready;

   always_comb begin
      for (int n = 0; n < 3; n++) begin
         dsel[n]     = dac_source_select[n];
         dsel[n + 3] = volume_source_select[n];
      end
      for (int n = 0; n < 4; n++) begin
         dsel[n + 6] = mixer_input_source_select[n];
      end
   end

   for (genvar n = 0; n < 10; n++) begin : g_dst
      assign dfs[n] = (n < 3) ? dom_fstart[didx(converter_group_domain)]
                              : dom_fstart[didx(bus_dom[dsel[n]])];
      always_ff @(posedge clk_sys) begin
         if (!rst_b) begin
            dq_q[n] <= '0;
         end else if (dfs[n]) begin
            dq_q[n] <= bus_data[dsel[n]];
         end
      end
   end

   // lowest pending destination goes first
   always_comb begin
      pick = '0;
      for (int n = 9; n >= 0; n--) begin
         if (pend_q[n]) begin
            pick = 4'(n);
         end
      end
   end

   // a new frame wins over the clear of the same entry
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~(10'((|pend_q && f_ready)) << pick)) | dfs;
      end
   end

   ahr_fifo #(
      .WIDTH (68),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_valid  (|pend_q),
      .in_ready  (f_ready),
      .in_data   ({pick, dq_q[pick]}),
      .out_valid (dest_valid),
      .out_ready (dest_ready),
      .out_data  ({dest_index, dest_data})
   );
endmodule // ahr_router
`default_nettype wire

// ===== dv/ahr_router_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ahr_router_asserts #(
   parameter int BCK_HALF = 8
) (
   input wire logic            clk_sys,
   input wire logic            rst_b,
   input wire logic [1:0]      master_slave_select,
   input wire logic [1:0][2:0] master_domain_select,
   input wire logic [2:0][2:0] input_clock_pair_select,
   input wire logic [2:0][2:0] output_port_domain,
   input wire logic [1:0]      bit_clock_pin_o,
   input wire logic [1:0]      bit_clock_pin_oe,
   input wire logic [1:0]      frame_clock_pin_oe,
   input wire logic [2:0]      serial_out_pin,
   input wire logic [2:0][2:0] in_port_domain,
   input wire logic            dest_valid,
   input wire logic            dest_ready,
   input wire logic [3:0]      dest_index,
   input wire logic [63:0]     dest_data
);
   // everything here lives in the system clock domain
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   slave_pins_a: assert property (
      (!master_slave_select[0]) [*3] |-> !bit_clock_pin_oe[0] && !frame_clock_pin_oe[0]
      && !bit_clock_pin_o[0]) else $error("slave pair drives its pins");
   master_pins_a: assert property (
      master_slave_select[1] [*3] |-> bit_clock_pin_oe[1] && frame_clock_pin_oe[1])
      else $error("master pair does not drive its pins");
   // half period of the default divider; any other divider needs this count changed
   bck_half_a: assert property (
      $rose(bit_clock_pin_o[1]) |-> bit_clock_pin_o[1] [*8] ##1 !bit_clock_pin_o[1])
      else $error("master bit clock half period wrong");
   idle_out_a: assert property (
      output_port_domain[2] == 3'h0 |-> !serial_out_pin[2])
      else $error("output without domain is not idle");
   tied_in_a: assert property (
      (input_clock_pair_select[2] == 3'h0) [*4] |-> in_port_domain[2] == 3'h0)
      else $error("tied low input has a domain");
   in_slave_a: assert property (
      (input_clock_pair_select[0] == 3'h1 && !master_slave_select[0]) [*4]
      |-> in_port_domain[0] == 3'h1) else $error("slave pair input domain wrong");
   in_master_a: assert property (
      (input_clock_pair_select[1] == 3'h2 && master_slave_select[1]
      && master_domain_select[1] == 3'h2) [*4] |-> in_port_domain[1] == 3'h2)
      else $error("master pair input domain wrong");
   dest_hold_a: assert property (
      dest_valid && !dest_ready |=> dest_valid && $stable(dest_index) && $stable(dest_data))
      else $error("stalled destination word changed");
endmodule // ahr_router_asserts
bind ahr_router ahr_router_asserts #(.BCK_HALF(BCK_HALF)) u_chk (.*);
`default_nettype wire

// ===== dv/ahr_link_partner.sv
`timescale 1ns/100ps
`default_nettype none
// far device as clock master: free running i2s clocks, 160 ns bit period
module ahr_link_partner (
   output logic             bit_clock,
   output logic             frame_clock,
   output logic             data,
   input  wire logic [63:0] word
);
   int          n;
   logic [63:0] w;
   // i2s framing, launch at falling edge
   initial begin
      bit_clock = 1'b1;
      frame_clock = 1'b0;
      data = 1'b0;
      n = 0;
      w = '0;
      forever begin
         #80 bit_clock = 1'b0;
         frame_clock = (n >= 32);
         data = w[63 - ((n + 63) % 64)]; // old right lsb still on at frame start
         if (n == 0) w = word; // word swaps only at frame start
         n = (n + 1) % 64;
         #80 bit_clock = 1'b1;
      end
   end
endmodule // ahr_link_partner
`default_nettype wire

// ===== dv/ahr_router_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ahr_router_tb import ahr_pkg::*; ;
   logic                  clk_sys, rst_b, dest_ready, dest_valid, armed;
   wire logic [1:0]       bit_clock_pin_i, frame_clock_pin_i;
   logic      [1:0]       bit_clock_pin_o, bit_clock_pin_oe, frame_clock_pin_o, frame_clock_pin_oe;
   wire logic [2:0]       serial_in_pin;
   logic      [2:0]       serial_out_pin, in_bit_order, in_start_timing, out_bit_order;
   logic      [2:0]       out_start_timing, converter_group_domain, stereo_adc_domain;
   logic      [1:0]       master_slave_select, edge_polarity_bit, sd_rand;
   logic      [1:0][2:0]  clock_format_field, master_domain_select, mixer_domain;
   logic      [2:0][2:0]  input_clock_pair_select, output_port_domain, volume_domain;
   logic      [2:0][2:0]  in_port_domain;
   logic      [2:0][1:0]  in_slot_length, in_word_length, out_slot_length, out_word_length;
   logic      [7:0][5:0]  out1_pair_source_select;
   logic      [1:0][5:0]  out23_source_select;
   logic      [2:0][5:0]  dac_source_select, volume_source_select;
   logic      [3:0][5:0]  mixer_input_source_select;
   logic      [7:0][63:0] int_src_data;
   logic      [3:0]       dest_index;
   logic      [3:0]       rdy_cnt = 4'h0;
   logic      [63:0]      dest_data, word;
   logic      [31:0]      seed, mask, r;
   logic      [63:0]      exp_q [$];
   wire logic             peer_bck, peer_frame, peer_sd;
   int                    errors, n_tests;
   // pair two is ours as master, so its pins read back our own drive, else pulled low
   assign bit_clock_pin_i   = {bit_clock_pin_oe[1] & bit_clock_pin_o[1], peer_bck};
   assign frame_clock_pin_i = {frame_clock_pin_oe[1] & frame_clock_pin_o[1], peer_frame};
   assign serial_in_pin     = {sd_rand, peer_sd};
   ahr_router u_dut (.*);
   ahr_link_partner u_peer (.bit_clock(peer_bck), .frame_clock(peer_frame), .data(peer_sd),
                            .word(word));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // sink stalls one clock in four so the fifo has to hold words
   always @(posedge clk_sys) begin
      rdy_cnt <= rdy_cnt + 4'h1;
      dest_ready <= (rdy_cnt[1:0] != 2'h3);
      sd_rand <= seed[1:0] ^ rdy_cnt[1:0];
   end
   // dac one and volume one both carry pin one, so each takes the oldest note
   always @(posedge clk_sys) begin
      if (dest_valid === 1'b1 && dest_ready) begin
         if ((dest_index === 4'h0 || dest_index === 4'h3) && exp_q.size() > 0) begin
            check("dest_data", dest_data, exp_q.pop_front());
         end
         if (armed && dest_index === 4'h2) check("dac3_data", dest_data, 64'h0);
      end
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      complete_run();
   end
   initial begin
      {rst_b, armed, errors, n_tests, edge_polarity_bit, clock_format_field} = '0;
      {mixer_domain, volume_domain, in_slot_length, in_word_length, out_slot_length} = '0;
      {out_word_length, in_bit_order, in_start_timing, out_bit_order, out_start_timing} = '0;
      {out23_source_select, mixer_input_source_select, stereo_adc_domain} = '0;
      {int_src_data, word} = '0;
      seed = 32'hD685;
      // random slots stay longer than these fixed 16-bit words
      in_word_length = 6'h28;
      out_word_length = 6'h2A;
      // pin one on slave pair one, pin two on master pair two
      master_slave_select = 2'h2;
      master_domain_select = {3'h2, 3'h0};
      input_clock_pair_select = {3'h0, 3'h2, 3'h1};
      output_port_domain = {6'h00, 3'h1};
      converter_group_domain = 3'h1;
      // pin one pair to dac one, volume one; dac three unavailable
      out1_pair_source_select = {42'h0, 6'h01};
      dac_source_select = {6'h3F, 6'h00, 6'h01};
      volume_source_select = {12'h000, 6'h01};
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         @(posedge clk_sys);
         r = lfsr();
         {mixer_input_source_select, out_bit_order, out_start_timing, edge_polarity_bit[1],
          in_start_timing[2]} <= r;
         r = lfsr();
         {out_slot_length, out23_source_select, in_slot_length[2:1], in_bit_order[2:1],
          mixer_domain[0][1:0]} <= r[25:0] | 26'h1500050;
         int_src_data[p] <= {lfsr(), lfsr()};
         word <= {lfsr(), lfsr()};
         // every format on pair two; pin one words 24, 20, 16 in 32, 16 in 24
         clock_format_field[1] <= (p == 0) ? 3'h0 : {1'b1, 2'(p)};
         in_word_length[0] <= (p == 3) ? 2'h2 : 2'(p);
         in_slot_length[0] <= (p == 3) ? 2'h0 : 2'h3;
         repeat (6144) @(posedge clk_sys);
         // msb first, word at slot start, padding reads as zero
         mask = ~(32'hFFFFFFFF >> (p == 3 ? 16 : 24 - 4 * p));
         repeat (6) exp_q.push_back({word[63:32] & mask, word[31:0] & mask});
         armed = 1'b1;
         for (int i = 0; i < 5000 && exp_q.size() > 0; i++) @(posedge clk_sys);
         armed = 1'b0;
         check("notes_left", 64'(exp_q.size()), 64'h0);
      end
      complete_run();
   end
endmodule // ahr_router_tb
`default_nettype wire
